// ===== scp_pkg.sv
// shared constants, state codes and mode helpers for the serial client port
// assumes both ends and the carrier import it whole

package scp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // word lengths

    localparam int            SCP_WORD_MAX = 16;
    localparam int            SCP_WORD_MIN = 8;
    localparam int            SCP_LEN_W    = 5;
    localparam int            SCP_IDX_W    = 4;

    ////////////////////////////////////////////////////////////////////////////
    // reset values and line levels

    localparam logic [SCP_WORD_MAX-1:0] SCP_RESET_WORD = 16'h0000;
    localparam logic                    SCP_MISO_IDLE  = 1'b1;
    localparam logic                    SCP_CS_IDLE    = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // link timing: host half period of the serial clock in ref_clk cycles

    localparam int            SCP_SCK_HALF_DEF = 8;
    localparam int            SCP_DIV_W        = 8;

    ////////////////////////////////////////////////////////////////////////////
    // host sequencer states

    typedef enum logic [2:0] {
        SCP_H_IDLE = 3'h1,
        SCP_H_RUN  = 3'h2,
        SCP_H_GAP  = 3'h4
    } scp_hstate_t;

    ////////////////////////////////////////////////////////////////////////////
    // mode helpers, mode = {polarity, phase}

    // modes 0 and 3 capture on the rising edge, modes 1 and 2 on the falling one
    function automatic logic scp_cap_rise(input logic [1:0] mode);
        return mode[1] ~^ mode[0];
    endfunction

    function automatic logic scp_idle_high(input logic [1:0] mode);
        return mode[1];
    endfunction

    // lengths outside 8..16 are forced into range
    function automatic logic [SCP_LEN_W-1:0] scp_clamp_len(input logic [SCP_LEN_W-1:0] len);
        if (len < SCP_LEN_W'(SCP_WORD_MIN))
            return SCP_LEN_W'(SCP_WORD_MIN);
        else if (len > SCP_LEN_W'(SCP_WORD_MAX))
            return SCP_LEN_W'(SCP_WORD_MAX);
        else
            return len;
    endfunction

endpackage

// ===== scp_if.sv
// four-wire serial link between the host end and the client end
// assumes a pull-up on the client-out wire while no client drives it

`timescale 1ns/1ps

interface scp_if;
    import scp_pkg::*;

    logic sck;
    logic cs_n;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic miso_line;

    // resolved wire level, pulled high when released
    assign miso_line = miso_oe ? miso : SCP_MISO_IDLE;

    modport dev (input sck, input cs_n, input mosi, output miso, output miso_oe);
    modport hst (output sck, output cs_n, output mosi, input miso_line);

endinterface

// ===== scp_client.sv
// client end of the four-wire serial link
// assumes sck, cs_n and mosi arrive from another domain and are sampled by ref_clk

`timescale 1ns/1ps

module scp_client
    import scp_pkg::*;
#(
    parameter int W = SCP_WORD_MAX
)(
    input  wire logic                 ref_clk,
    input  wire logic                 rstn,
    input  wire logic                 clk_en,
    scp_if.dev                        link,
    input  wire logic [1:0]           cfg_mode,
    input  wire logic [SCP_LEN_W-1:0] cfg_len,
    input  wire logic [W-1:0]         tx_data,
    input  wire logic                 tx_wr,
    output logic      [W-1:0]         rx_data,
    output logic                      rx_valid,
    output logic                      xfer_active
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic sck_s1_q;
    logic sck_s2_q;
    logic sck_p_q;
    logic cs_s1_q;
    logic cs_s2_q;
    logic cs_p_q;
    logic mosi_s1_q;
    logic mosi_s2_q;

    // the serial clock is oversampled, so the host must stay well below ref_clk/4
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sck_s1_q  <= 1'b0;
            sck_s2_q  <= 1'b0;
            sck_p_q   <= 1'b0;
            cs_s1_q   <= SCP_CS_IDLE;
            cs_s2_q   <= SCP_CS_IDLE;
            cs_p_q    <= SCP_CS_IDLE;
            mosi_s1_q <= 1'b0;
            mosi_s2_q <= 1'b0;
        end
        else if (clk_en)
        begin
            sck_s1_q  <= link.sck;
            sck_s2_q  <= sck_s1_q;
            sck_p_q   <= sck_s2_q;
            cs_s1_q   <= link.cs_n;
            cs_s2_q   <= cs_s1_q;
            cs_p_q    <= cs_s2_q;
            mosi_s1_q <= link.mosi;
            mosi_s2_q <= mosi_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // shift state

    logic [W-1:0]         sh_q;
    logic [W-1:0]         sh_d;
    logic [W-1:0]         hold_q;
    logic [W-1:0]         hold_d;
    logic                 hold_v_q;
    logic                 hold_v_d;
    logic                 wrote_q;
    logic                 wrote_d;
    logic [SCP_LEN_W-1:0] cnt_q;
    logic [SCP_LEN_W-1:0] cnt_d;
    logic                 miso_q;
    logic                 miso_d;
    logic                 oe_q;
    logic                 oe_d;
    logic [W-1:0]         rx_data_q;
    logic [W-1:0]         rx_data_d;
    logic                 rx_valid_q;
    logic                 rx_valid_d;
    logic                 act_q;
    logic                 act_d;

    logic [SCP_LEN_W-1:0] len;
    logic [SCP_IDX_W-1:0] last;
    logic                 cs_fall;
    logic                 sel;
    logic                 sck_rise;
    logic                 sck_fall;
    logic                 cap;
    logic                 shf;
    logic [W-1:0]         load_w;
    logic [W-1:0]         shifted;
    logic [W-1:0]         mask;

    always_comb
    begin
        len      = scp_clamp_len(cfg_len);
        last     = SCP_IDX_W'(len - SCP_LEN_W'(1));
        mask     = {W{1'b1}} >> (W - int'(len));
        cs_fall  = cs_p_q & ~cs_s2_q;
        sel      = ~cs_s2_q & ~cs_fall;
        sck_rise = ~sck_p_q & sck_s2_q;
        sck_fall = sck_p_q & ~sck_s2_q;
        cap      = sel & (scp_cap_rise(cfg_mode) ? sck_rise : sck_fall);
        shf      = sel & (scp_cap_rise(cfg_mode) ? sck_fall : sck_rise);
        shifted  = {sh_q[W-2:0], mosi_s2_q};

        sh_d       = sh_q;
        hold_d     = hold_q;
        hold_v_d   = hold_v_q;
        wrote_d    = wrote_q;
        cnt_d      = cnt_q;
        miso_d     = miso_q;
        rx_data_d  = rx_data_q;
        rx_valid_d = 1'b0;
        oe_d       = ~cs_s2_q;
        act_d      = ~cs_s2_q;

        if (tx_wr)
        begin
            if (!wrote_q)
            begin
                sh_d    = tx_data;
                wrote_d = 1'b1;
            end
            else
            begin
                hold_d   = tx_data;
                hold_v_d = 1'b1;
            end
        end

        // after the first write since reset, a write in the same cycle as the select edge waits for the next transfer
        load_w = hold_v_q ? hold_q : sh_d;
        if (cs_fall)
        begin
            sh_d     = load_w;
            hold_v_d = tx_wr & wrote_q;
            cnt_d    = '0;
            miso_d   = load_w[last];
        end
        else if (cap)
        begin
            sh_d  = shifted;
            cnt_d = cnt_q + SCP_LEN_W'(1);
            if (cnt_q == SCP_LEN_W'(last))
            begin
                cnt_d      = '0;
                rx_data_d  = shifted & mask;
                rx_valid_d = 1'b1;
            end
        end
        else if (shf)
        begin
            miso_d = sh_q[last];
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sh_q       <= SCP_RESET_WORD[W-1:0];
            hold_q     <= SCP_RESET_WORD[W-1:0];
            hold_v_q   <= 1'b0;
            wrote_q    <= 1'b0;
            cnt_q      <= '0;
            miso_q     <= 1'b0;
            oe_q       <= 1'b0;
            rx_data_q  <= SCP_RESET_WORD[W-1:0];
            rx_valid_q <= 1'b0;
            act_q      <= 1'b0;
        end
        else if (clk_en)
        begin
            sh_q       <= sh_d;
            hold_q     <= hold_d;
            hold_v_q   <= hold_v_d;
            wrote_q    <= wrote_d;
            cnt_q      <= cnt_d;
            miso_q     <= miso_d;
            oe_q       <= oe_d;
            rx_data_q  <= rx_data_d;
            rx_valid_q <= rx_valid_d;
            act_q      <= act_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign link.miso    = miso_q;
    assign link.miso_oe = oe_q;
    assign rx_data      = rx_data_q;
    assign rx_valid     = rx_valid_q;
    assign xfer_active  = act_q;

endmodule

// ===== scp_host.sv
// host end of the four-wire serial link, makes the serial clock by division
// assumes the client-out wire is resolved by the carrier and sampled here

`timescale 1ns/1ps

module scp_host
    import scp_pkg::*;
#(
    parameter int W    = SCP_WORD_MAX,
    parameter int HALF = SCP_SCK_HALF_DEF
)(
    input  wire logic                 ref_clk,
    input  wire logic                 rstn,
    input  wire logic                 clk_en,
    scp_if.hst                        link,
    input  wire logic [1:0]           cfg_mode,
    input  wire logic [SCP_LEN_W-1:0] cfg_len,
    input  wire logic [W-1:0]         tx_word,
    input  wire logic                 start,
    output logic                      busy,
    output logic      [W-1:0]         rx_word,
    output logic                      rx_done
);

    ////////////////////////////////////////////////////////////////////////////
    // client-out synchroniser

    logic miso_s1_q;
    logic miso_s2_q;

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            miso_s1_q <= 1'b0;
            miso_s2_q <= 1'b0;
        end
        else if (clk_en)
        begin
            miso_s1_q <= link.miso_line;
            miso_s2_q <= miso_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer

    scp_hstate_t          st_q;
    scp_hstate_t          st_d;
    logic [SCP_DIV_W-1:0] div_q;
    logic [SCP_DIV_W-1:0] div_d;
    logic [SCP_LEN_W:0]   edg_q;
    logic [SCP_LEN_W:0]   edg_d;
    logic [SCP_LEN_W-1:0] caps_q;
    logic [SCP_LEN_W-1:0] caps_d;
    logic [W-1:0]         tx_q;
    logic [W-1:0]         tx_d;
    logic [W-1:0]         rx_q;
    logic [W-1:0]         rx_d;
    logic                 sck_q;
    logic                 sck_d;
    logic                 cs_q;
    logic                 cs_d;
    logic                 mosi_q;
    logic                 mosi_d;
    logic                 busy_q;
    logic                 busy_d;
    logic [W-1:0]         rxw_q;
    logic [W-1:0]         rxw_d;
    logic                 done_q;
    logic                 done_d;

    logic [SCP_LEN_W-1:0] len;
    logic [SCP_IDX_W-1:0] last;
    logic                 tick;

    always_comb
    begin
        len  = scp_clamp_len(cfg_len);
        last = SCP_IDX_W'(len - SCP_LEN_W'(1));
        // oversampling by the client caps the serial clock far below the usual rates
        tick = (div_q == SCP_DIV_W'(HALF - 1));

        st_d   = st_q;
        div_d  = tick ? '0 : div_q + SCP_DIV_W'(1);
        edg_d  = edg_q;
        caps_d = caps_q;
        tx_d   = tx_q;
        rx_d   = rx_q;
        sck_d  = sck_q;
        cs_d   = cs_q;
        mosi_d = mosi_q;
        rxw_d  = rxw_q;
        done_d = 1'b0;

        case (st_q)
            SCP_H_IDLE:
            begin
                div_d = '0;
                sck_d = scp_idle_high(cfg_mode);
                cs_d  = SCP_CS_IDLE;
                if (start)
                begin
                    tx_d   = tx_word;
                    rx_d   = '0;
                    edg_d  = '0;
                    caps_d = '0;
                    cs_d   = ~SCP_CS_IDLE;
                    mosi_d = tx_word[last];
                    st_d   = SCP_H_RUN;
                end
            end
            SCP_H_RUN:
            begin
                if (tick)
                begin
                    if (edg_q == {len, 1'b0})
                    begin
                        cs_d = SCP_CS_IDLE;
                        st_d = SCP_H_GAP;
                    end
                    else
                    begin
                        sck_d = ~sck_q;
                        edg_d = edg_q + (SCP_LEN_W+1)'(1);
                        if (~sck_q == scp_cap_rise(cfg_mode))
                        begin
                            rx_d   = {rx_q[W-2:0], miso_s2_q};
                            caps_d = caps_q + SCP_LEN_W'(1);
                        end
                        else if (caps_q < len)
                        begin
                            mosi_d = tx_q[last - SCP_IDX_W'(caps_q)];
                        end
                    end
                end
            end
            SCP_H_GAP:
            begin
                // keeps select high long enough for the client to see the edge
                if (tick)
                begin
                    rxw_d  = rx_q & ({W{1'b1}} >> (W - int'(len)));
                    done_d = 1'b1;
                    st_d   = SCP_H_IDLE;
                end
            end
            default:
            begin
                cs_d = SCP_CS_IDLE;
                st_d = SCP_H_IDLE;
            end
        endcase
        busy_d = (st_d != SCP_H_IDLE);
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q   <= SCP_H_IDLE;
            div_q  <= '0;
            edg_q  <= '0;
            caps_q <= '0;
            tx_q   <= '0;
            rx_q   <= '0;
            sck_q  <= 1'b0;
            cs_q   <= SCP_CS_IDLE;
            mosi_q <= 1'b0;
            busy_q <= 1'b0;
            rxw_q  <= '0;
            done_q <= 1'b0;
        end
        else if (clk_en)
        begin
            st_q   <= st_d;
            div_q  <= div_d;
            edg_q  <= edg_d;
            caps_q <= caps_d;
            tx_q   <= tx_d;
            rx_q   <= rx_d;
            sck_q  <= sck_d;
            cs_q   <= cs_d;
            mosi_q <= mosi_d;
            busy_q <= busy_d;
            rxw_q  <= rxw_d;
            done_q <= done_d;
        end
    end

    assign link.sck  = sck_q;
    assign link.cs_n = cs_q;
    assign link.mosi = mosi_q;
    assign busy      = busy_q;
    assign rx_word   = rxw_q;
    assign rx_done   = done_q;

endmodule

// ===== scp_monitor.sv
// link checker: watches the four wires between host end and client end
// assumes one ref_clk domain and the host half period given by HALF
`timescale 1ns/1ps

module scp_monitor #(
    parameter int HALF = 8
)(
    input  wire logic ref_clk,
    input  wire logic rstn,
    input  wire logic sck,
    input  wire logic cs_n,
    input  wire logic mosi,
    input  wire logic miso,
    input  wire logic miso_oe,
    input  wire logic miso_line
);
    logic       sck_q;
    logic       cs_q;
    logic       evt;
    logic [7:0] since_q;
    logic [7:0] since_d;
    logic [5:0] edges_q;
    logic [5:0] edges_d;

    ////////////////////////////////////////////////////////////////////////////
    // select edges count as events too, client-out may settle after deselect
    always_comb
    begin
        evt     = (sck != sck_q) || (cs_n != cs_q);
        since_d = evt ? 8'h00 : ((since_q == 8'hff) ? since_q : since_q + 8'h01);
        edges_d = cs_n ? 6'h00 : edges_q + 6'(sck != sck_q);
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sck_q   <= 1'b0;
            cs_q    <= 1'b1;
            since_q <= 8'h00;
            edges_q <= 6'h00;
        end
        else
        begin
            sck_q   <= sck;
            cs_q    <= cs_n;
            since_q <= since_d;
            edges_q <= edges_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    AST_SEL_DRIVES: assert property ($fell(cs_n) |-> ##[1:6] (miso_oe || cs_n))
        else $error("client-out not driven after select");
    AST_DESEL_FREE: assert property (cs_n [*6] |-> !miso_oe)
        else $error("client-out driven while deselected");
    AST_MISO_STEP: assert property (miso_oe && $past(miso_oe) && $changed(miso) |-> since_q inside {[1:4]})
        else $error("client-out moved away from a clock edge");
    AST_MOSI_STEP: assert property (!cs_n && $changed(mosi) |-> evt || since_q == 8'h00)
        else $error("host-out moved away from a clock edge");
    AST_SCK_GAP: assert property (!cs_n && $changed(sck) |-> since_q >= 8'(HALF - 1))
        else $error("serial clock half period too short");
    AST_EDGE_COUNT: assert property ($rose(cs_n) |-> !edges_q[0] && edges_q inside {[16:32]})
        else $error("clock edge count per frame wrong");
    AST_SEL_HOLD: assert property ($fell(cs_n) |-> !cs_n [*8])
        else $error("select pulse too short");
    AST_QUIET_EDGE: assert property ($fell(cs_n) || $rose(cs_n) |-> $stable(sck))
        else $error("serial clock moved at a select edge");

    COV_SHORT: cover property ($rose(cs_n) && edges_q == 6'd16);
    COV_LONG: cover property ($rose(cs_n) && edges_q == 6'd32);
    COV_PULL: cover property (!miso_oe && miso_line);
endmodule

// ===== spi_client_shift_port_test.sv
// self-checking bench: host and client joined on one link, a second client driven by hand
// assumes the package, carrier, both ends and the link checker compile first
`timescale 1ns/1ps

module spi_client_shift_port_test;
    import scp_pkg::*;

    localparam int HALF = SCP_SCK_HALF_DEF;

    logic                 ref_clk = 1'b0;
    logic                 rstn    = 1'b0;
    logic                 clk_en  = 1'b1;
    logic [1:0]           mode    = 2'h0;
    logic [SCP_LEN_W-1:0] len     = 5'h08;
    logic [15:0]          c_tx    = 16'h0000;
    logic                 c_wr    = 1'b0;
    logic [15:0]          h_tx    = 16'h0000;
    logic                 start   = 1'b0;
    logic                 busy, rx_done, c_valid, c_act, b_valid, b_act;
    logic [15:0]          h_rx, c_rx, b_rx;
    int                   err_count = 0, check_count = 0, rv_count = 0, bv_count = 0, seed = 32'h56d1;
    int                   shreg = 0, held = 0, written = 0, has_held = 0;

    scp_if link ();
    scp_if link2 ();

    scp_host #(.HALF(HALF)) u_scp_host (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en), .link(link),
        .cfg_mode(mode), .cfg_len(len), .tx_word(h_tx), .start(start), .busy(busy), .rx_word(h_rx),
        .rx_done(rx_done));
    scp_client u_scp_client (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en), .link(link), .cfg_mode(mode),
        .cfg_len(len), .tx_data(c_tx), .tx_wr(c_wr), .rx_data(c_rx), .rx_valid(c_valid), .xfer_active(c_act));
    // second client never written: its first frame must carry zeros
    scp_client u_scp_client_b (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en), .link(link2), .cfg_mode(mode),
        .cfg_len(len), .tx_data(16'h0000), .tx_wr(1'b0), .rx_data(b_rx), .rx_valid(b_valid), .xfer_active(b_act));
    scp_monitor #(.HALF(HALF)) u_scp_monitor (.ref_clk(ref_clk), .rstn(rstn), .sck(link.sck), .cs_n(link.cs_n),
        .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe), .miso_line(link.miso_line));

    always #20 ref_clk = ~ref_clk;

    // counted on the falling edge so the pulse has settled
    always @(negedge ref_clk)
    begin
        if (c_valid === 1'b1)
            rv_count++;
        if (b_valid === 1'b1)
            bv_count++;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic cwrite(input logic [15:0] w);
        @(posedge ref_clk);
        c_tx <= w;
        c_wr <= 1'b1;
        @(posedge ref_clk);
        c_wr <= 1'b0;
        if (written)
            has_held = 1;
        else
            shreg = w;
        held    = w;
        written = 1;
    endtask

    task automatic xfer(input int md, input int ln, input logic [15:0] hw);
        int n;
        int msk;
        int rv0;
        int lc;
        int bz;
        int ac;
        // lengths outside the legal range are clamped by both ends
        lc  = (ln < SCP_WORD_MIN) ? SCP_WORD_MIN : ((ln > SCP_WORD_MAX) ? SCP_WORD_MAX : ln);
        msk = (1 << lc) - 1;
        bz  = 0;
        ac  = 0;
        if (has_held)
            shreg = held;
        has_held = 0;
        rv0      = rv_count;
        @(posedge ref_clk);
        mode <= md[1:0];
        len  <= ln[4:0];
        h_tx <= hw;
        repeat (2) @(posedge ref_clk);
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        n = 0;
        while (n < 1000 && rx_done !== 1'b1)
        begin
            @(posedge ref_clk);
            #1;
            n++;
            bz += int'(busy === 1'b1);
            ac += int'(c_act === 1'b1);
        end
        // counted from the edge that takes start, one cycle after it is driven
        chk_word(16'(n), 16'((2 * lc + 2) * HALF));
        chk_word(16'(bz), 16'((2 * lc + 2) * HALF - 1));
        chk_word(16'(ac), 16'((2 * lc + 1) * HALF));
        chk_word(h_rx, 16'(shreg & msk));
        chk_word(c_rx, hw & 16'(msk));
        chk_flag(rv_count == rv0 + 1, 1'b1);
        shreg = hw & msk;
    endtask

    // bench as host, mode 0, 8 bits, 320 ns serial clock
    task automatic frame2(input logic [7:0] w, output logic [7:0] got);
        link2.cs_n = 1'b0;
        link2.mosi = w[7];
        for (int i = 7; i >= 0; i--)
        begin
            #160;
            got[i]    = link2.miso_line;
            if (i == 7)
                chk_flag(b_act, 1'b1);
            link2.sck = 1'b1;
            #160;
            link2.sck = 1'b0;
            if (i > 0)
                link2.mosi = w[i-1];
        end
        #160;
        link2.cs_n = 1'b1;
        link2.mosi = ~link2.mosi;
        #1000;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [7:0]  g;
        logic [15:0] w;
        int          ln;
        link2.sck  = 1'b0;
        link2.cs_n = 1'b1;
        link2.mosi = 1'b0;
        ln = 8;
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge ref_clk);
        xfer(0, 8, 16'h00a5);
        for (int k = 0; k < 12; k++)
        begin
            w = 16'($random(seed));
            if (k % 3 != 2)
            begin
                ln = (k < 4) ? 8 + 8 * (k % 2) : 8 + int'($unsigned($random(seed)) % 9);
                cwrite(w);
            end
            if (k == 4)
                cwrite(~w);
            xfer(k % 4, ln, 16'($random(seed)));
        end
        $display("test modes done");
        // a write while frozen must be lost, so the next frame sends back the word received in the last one
        @(posedge ref_clk);
        clk_en <= 1'b0;
        c_tx   <= 16'h3c3c;
        c_wr   <= 1'b1;
        repeat (3) @(posedge ref_clk);
        clk_en <= 1'b1;
        c_wr   <= 1'b0;
        xfer(1, ln, 16'h0f0f);
        cwrite(16'h9e37);
        xfer(2, 20, 16'h1234);
        xfer(3, 4, 16'h00c3);
        $display("test clock enable and length clamp done");
        @(posedge ref_clk);
        mode <= 2'h0;
        len  <= 5'h08;
        #13;
        // the far host breaks select discipline: clock runs while deselected
        repeat (4)
        begin
            #160;
            link2.sck = ~link2.sck;
        end
        chk_flag(link2.miso_oe, 1'b0);
        frame2(8'h5c, g);
        chk_word({8'h00, g}, 16'h0000);
        chk_word(b_rx, 16'h005c);
        chk_word(16'(bv_count), 16'h0001);
        chk_flag(b_act, 1'b0);
        frame2(8'h3a, g);
        chk_word({8'h00, g}, 16'h005c);
        chk_word(b_rx, 16'h003a);
        chk_word(16'(bv_count), 16'h0002);
        $display("test hand driven link done");
        final_report;
    end

    initial
    begin
        #(40 * 20000);
        err_count++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        final_report;
    end
endmodule
